/* rtl/pwr_seq_ctrl.sv */
`timescale 1ns/10ps
`include "pwr_seq_defs.svh"

// Operation
// R1 - Reset loads defaults; start if pin high
// R2 - Startup reloads voltage defaults first
// R3 - Startup clears sequencing disable; no-seq reads zero
// R4 - Startup loads preset enables then sequences
// R5 - Startup sets restart-after-fault to one
// R6 - Enable pin acts on rising edge
// R7 - Falling edge clears enables, drops bias
// R8 - Falling edge after register shutdown does nothing
// R9 - Pin tied high starts after reset
// R10 - Enable bits drive supplies in order
// R11 - Host never mixes pin and bus control
// R12 - Voltage write applies at bus acknowledge
// R13 - Fault drops outputs, flags, reloads defaults; bias_on stays high in an undervoltage fault as well
// R14 - Fault end restarts only if enabled
// R15 - Thermal fault keeps bias, logs flag
// R16 - Pin or bus shutdown accepted anytime; a pin fall during a fault is ignored and the restart still follows if enabled
// R17 - Fault flags clear by write-one only
// R18 - Supply loss reset clears fault flags
// R19 - Power-good sets at 90, clears 85
// R20 - Interrupt low on fault flag if enabled
// R21 - Write-one releases; persisting fault reasserts
// R22 - Interrupt enable resets to zero
// R23 - No-seq startup turns on one supply
// R24 - Sequencing uses power-good of previous supply
// R25 - Host disables sequencing before toggling
// R26 - Pins and detectors filtered to clean edges
module pwr_seq_ctrl #(
  parameter bit SEQ_ENABLED = 1'b1,
  parameter logic [3:0] PRESET_EN = 4'hf,
  parameter logic [7:0] ORDER = 8'b11_10_00_01,
  parameter logic [7:0] VBUCK_DEF = 8'h10,
  parameter logic [7:0] VLDO_A_DEF = 8'h14,
  parameter logic [7:0] VLDO_B_DEF = 8'h14,
  parameter logic [7:0] VLDO_C_DEF = 8'h14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_pin,
  input wire logic undervoltage_lockout,
  input wire logic thermal_shutdown,
  input wire pwr_seq_pkg::rail_pct_type rail_pct,
  output logic buck_reg_on,
  output logic linear_reg_a_on,
  output logic linear_reg_b_on,
  output logic linear_reg_c_on,
  output logic bias_on,
  output logic [31:0] volt_settings,
  output logic fault_irq_n
);
  pwr_seq_pkg::pin_evt_type evt;
  pwr_seq_pkg::seq_state_type state_r;
  pwr_seq_pkg::seq_state_type state_nxt;
  pwr_seq_pkg::supply_vec_type en_r;
  pwr_seq_pkg::supply_vec_type on_r;
  pwr_seq_pkg::supply_vec_type on_nxt;
  pwr_seq_pkg::supply_vec_type pgood;
  logic seqdis_r;
  logic restart_r;
  logic inten_r;
  logic uv_flag_r;
  logic ts_flag_r;
  logic [7:0] volt_r [4];
  logic boot_r;
  logic fault_any;
  logic fault_prev_r;
  logic fault_end;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic w_en;
  logic w_st;
  logic w_ctrl;
  logic [2:0] w_volt;
  logic [7:0] rd_mux;
  logic start_go;
  logic stop_go;

  // Synchronised, filtered pin and fault detector views.
  pin_filter u_en (.pclk(pclk), .presetn(presetn), .ce(ce), .pin(enable_pin),
    .level(evt.en_level), .rise(evt.en_rise), .fall(evt.en_fall));
  pin_filter u_uv (.pclk(pclk), .presetn(presetn), .ce(ce), .pin(undervoltage_lockout),
    .level(evt.uv), .rise(), .fall());
  pin_filter u_ts (.pclk(pclk), .presetn(presetn), .ce(ce), .pin(thermal_shutdown),
    .level(evt.ts), .rise(), .fall());

  // Power-good monitors, one per rail.
  pgood_mon u_pg0 (.pclk(pclk), .presetn(presetn), .ce(ce), .on(on_r[0]),
    .pct(rail_pct.pct_buck), .good(pgood[0]));
  pgood_mon u_pg1 (.pclk(pclk), .presetn(presetn), .ce(ce), .on(on_r[1]),
    .pct(rail_pct.pct_a), .good(pgood[1]));
  pgood_mon u_pg2 (.pclk(pclk), .presetn(presetn), .ce(ce), .on(on_r[2]),
    .pct(rail_pct.pct_b), .good(pgood[2]));
  pgood_mon u_pg3 (.pclk(pclk), .presetn(presetn), .ce(ce), .on(on_r[3]),
    .pct(rail_pct.pct_c), .good(pgood[3]));

  // Rank of a supply in the sequencing order (0 = first).
  function automatic logic [1:0] rank_of(input logic [1:0] idx);
    logic [1:0] r;
    r = 2'd0;
    for (int k = 0; k < 4; k++) begin
      if (ORDER[2*k +: 2] == idx) r = k[1:0];
    end
    return r;
  endfunction

  // Bus decode; single-cycle access, zero wait states.
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign hit = (paddr == `ADDR_ENABLE) || (paddr == `ADDR_STATUS) || (paddr == `ADDR_VBUCK) ||
               (paddr == `ADDR_VLDO_A) || (paddr == `ADDR_VLDO_B) || (paddr == `ADDR_VLDO_C) ||
               (paddr == `ADDR_CTRL);
  assign w_en = wr_acc && (paddr == `ADDR_ENABLE);
  assign w_st = wr_acc && (paddr == `ADDR_STATUS);
  assign w_ctrl = wr_acc && (paddr == `ADDR_CTRL);
  assign w_volt = (paddr == `ADDR_VBUCK) ? 3'd4 : (paddr == `ADDR_VLDO_A) ? 3'd5 :
                  (paddr == `ADDR_VLDO_B) ? 3'd6 : (paddr == `ADDR_VLDO_C) ? 3'd7 : 3'd0;

  // Read data selection.
  assign rd_mux = (paddr == `ADDR_ENABLE) ? {2'b00, restart_r, seqdis_r & SEQ_ENABLED, en_r} : // R3
                  (paddr == `ADDR_STATUS) ? {2'b00, ts_flag_r, uv_flag_r, pgood} :
                  (paddr == `ADDR_VBUCK) ? volt_r[0] :
                  (paddr == `ADDR_VLDO_A) ? volt_r[1] :
                  (paddr == `ADDR_VLDO_B) ? volt_r[2] :
                  (paddr == `ADDR_VLDO_C) ? volt_r[3] :
                  (paddr == `ADDR_CTRL) ? {7'h00, inten_r} : 8'h00;

  // Fault detection and default startup triggers.
  assign fault_any = evt.uv || evt.ts;
  assign fault_end = fault_prev_r && !fault_any;
  assign start_go = !fault_any && (evt.en_rise || boot_r && evt.en_level || fault_end && restart_r); // R6 R9 R14
  assign stop_go = evt.en_fall && (en_r != 4'h0); // R7 R8

  // Supply drive: sequenced by the previous rail's power good, else direct.
  always_comb begin
    on_nxt = en_r;
    if (SEQ_ENABLED && !seqdis_r) begin
      for (int i = 0; i < 4; i++) begin
        for (int j = 0; j < 4; j++) begin
          if (en_r[j] && rank_of(j[1:0]) < rank_of(i[1:0]) && !pgood[j]) on_nxt[i] = 1'b0; // R10 R24
        end
      end
    end
    if (state_r != pwr_seq_pkg::ST_RUN) on_nxt = 4'h0; // R13 R15
  end

  // Sequencer state machine.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pwr_seq_pkg::ST_IDLE: begin
        if (fault_any) state_nxt = pwr_seq_pkg::ST_FAULT;
        else if (start_go) state_nxt = pwr_seq_pkg::ST_LOAD;
        else if (w_en && pwdata[3:0] != 4'h0) state_nxt = pwr_seq_pkg::ST_RUN;
      end
      pwr_seq_pkg::ST_LOAD: begin
        state_nxt = fault_any ? pwr_seq_pkg::ST_FAULT : pwr_seq_pkg::ST_RUN;
      end
      pwr_seq_pkg::ST_RUN: begin
        if (fault_any) state_nxt = pwr_seq_pkg::ST_FAULT;
        else if (stop_go || en_r == 4'h0) state_nxt = pwr_seq_pkg::ST_IDLE; // R16
        else if (start_go) state_nxt = pwr_seq_pkg::ST_LOAD;
      end
      pwr_seq_pkg::ST_FAULT: begin
        if (!fault_any) state_nxt = restart_r ? pwr_seq_pkg::ST_LOAD : pwr_seq_pkg::ST_IDLE; // R14
      end
      default: state_nxt = pwr_seq_pkg::ST_IDLE;
    endcase
  end

  // State, outputs and bus answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= pwr_seq_pkg::ST_IDLE;
      on_r <= 4'h0;
      fault_prev_r <= 1'b0;
      boot_r <= 1'b1;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      bias_on <= 1'b0;
      fault_irq_n <= 1'b1;
    end else if (ce) begin
      state_r <= state_nxt;
      on_r <= on_nxt;
      fault_prev_r <= fault_any;
      boot_r <= 1'b0; // R1
      if (rd_acc) prdata <= {24'h000000, rd_mux};
      pslverr <= psel && !penable && !hit;
      bias_on <= (state_nxt != pwr_seq_pkg::ST_IDLE); // R7 R15
      fault_irq_n <= !(inten_r && (uv_flag_r || ts_flag_r)); // R20
    end
  end

  assign pready = 1'b1;

  // Enable register with startup, shutdown and fault loading.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 4'(`RST_ENABLE); // R1
      seqdis_r <= 1'b0;
      restart_r <= 1'b1;
      inten_r <= 1'b0; // R22
    end else if (ce) begin
      if (fault_any && !fault_prev_r) begin
        en_r <= 4'h0; // R13
        seqdis_r <= 1'b0; // R13
      end else if (state_nxt == pwr_seq_pkg::ST_LOAD) begin
        en_r <= SEQ_ENABLED ? PRESET_EN : 4'h1; // R4 R23
        seqdis_r <= 1'b0; // R3
        restart_r <= 1'b1; // R5
      end else if (stop_go) begin
        en_r <= 4'h0; // R7
      end else if (w_en) begin
        en_r <= pwdata[3:0];
        seqdis_r <= pwdata[`EN_SEQDIS_BIT] & SEQ_ENABLED; // R3
        restart_r <= pwdata[`EN_RESTART_BIT];
      end
      if (w_ctrl) inten_r <= pwdata[`CTRL_INTEN_BIT];
    end
  end

  // Voltage settings: defaults on startup or fault, writes apply at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volt_r[0] <= `RST_VOLT;
      volt_r[1] <= `RST_VOLT;
      volt_r[2] <= `RST_VOLT;
      volt_r[3] <= `RST_VOLT;
    end else if (ce) begin
      if (boot_r || (fault_any && !fault_prev_r) || state_nxt == pwr_seq_pkg::ST_LOAD) begin
        volt_r[0] <= VBUCK_DEF; // R2 R13
        volt_r[1] <= VLDO_A_DEF;
        volt_r[2] <= VLDO_B_DEF;
        volt_r[3] <= VLDO_C_DEF;
      end else if (wr_acc && w_volt[2]) begin
        volt_r[w_volt[1:0]] <= pwdata[7:0]; // R12
      end
    end
  end

  // Sticky fault flags: set wins over write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_flag_r <= 1'b0; // R18
      ts_flag_r <= 1'b0;
    end else if (ce) begin
      uv_flag_r <= evt.uv || (uv_flag_r && !(w_st && pwdata[`ST_UV_BIT])); // R17 R21
      ts_flag_r <= evt.ts || (ts_flag_r && !(w_st && pwdata[`ST_TS_BIT])); // R15 R17 R21
    end
  end

  assign buck_reg_on = on_r[0];
  assign linear_reg_a_on = on_r[1];
  assign linear_reg_b_on = on_r[2];
  assign linear_reg_c_on = on_r[3];
  assign volt_settings = {volt_r[3], volt_r[2], volt_r[1], volt_r[0]};

  // Checks.
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      ce && inten_r && uv_flag_r |=> !fault_irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not asserted"); // R20

  property p_fault_off;
    @(posedge pclk) disable iff (!presetn)
      ce && fault_any |=> ##1 (on_r == 4'h0);
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("supplies on during fault"); // R13

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      ce && ts_flag_r && !w_st |=> ts_flag_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("thermal flag lost"); // R17

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      ce && state_r == pwr_seq_pkg::ST_LOAD |-> (en_r == (SEQ_ENABLED ? PRESET_EN : 4'h1)) && restart_r;
  endproperty
  a_start: assert property (p_start) else $error("startup preset not loaded"); // R4

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      ce && stop_go && !fault_any |=> en_r == 4'h0 ##1 on_r == 4'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("pin shutdown failed"); // R7

  property p_noseq;
    @(posedge pclk) disable iff (!presetn)
      !SEQ_ENABLED |-> !seqdis_r;
  endproperty
  a_noseq: assert property (p_noseq) else $error("seq disable set in no-seq part"); // R3

  property p_inten;
    @(posedge pclk) disable iff (!presetn)
      !inten_r |=> fault_irq_n || $past(inten_r);
  endproperty
  a_inten: assert property (p_inten) else $error("interrupt without enable"); // R22

  property p_restart_off;
    @(posedge pclk) disable iff (!presetn)
      ce && state_r == pwr_seq_pkg::ST_FAULT && !fault_any && !restart_r |=> state_r == pwr_seq_pkg::ST_IDLE;
  endproperty
  a_restart_off: assert property (p_restart_off) else $error("restarted with restart off"); // R14

  property p_bias_fault;
    @(posedge pclk) disable iff (!presetn)
      ce && state_r == pwr_seq_pkg::ST_FAULT && fault_any |=> bias_on;
  endproperty
  a_bias_fault: assert property (p_bias_fault) else $error("bias dropped during fault"); // R15

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
      ce && w_st && pwdata[`ST_TS_BIT] && !evt.ts |=> !ts_flag_r;
  endproperty
  a_w1c: assert property (p_w1c) else $error("thermal flag not cleared"); // R21

  property p_refault;
    @(posedge pclk) disable iff (!presetn)
      ce && evt.uv |=> uv_flag_r;
  endproperty
  a_refault: assert property (p_refault) else $error("undervoltage flag not set"); // R21

  property p_pg_off;
    @(posedge pclk) disable iff (!presetn)
      ce && on_r == 4'h0 |=> pgood == 4'h0;
  endproperty
  a_pg_off: assert property (p_pg_off) else $error("power good while rails off"); // R19

  property p_volt_now;
    @(posedge pclk) disable iff (!presetn)
      ce && wr_acc && paddr == `ADDR_VBUCK && state_r == pwr_seq_pkg::ST_RUN && state_nxt == pwr_seq_pkg::ST_RUN
        |=> volt_r[0] == $past(pwdata[7:0]);
  endproperty
  a_volt_now: assert property (p_volt_now) else $error("voltage write not applied at once"); // R12
endmodule

/* rtl/pwr_seq_defs.svh */
`ifndef PWR_SEQ_DEFS_SVH
`define PWR_SEQ_DEFS_SVH

// Register byte addresses on the APB bus.
`define ADDR_ENABLE 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_VBUCK 12'h008
`define ADDR_VLDO_A 12'h00c
`define ADDR_VLDO_B 12'h010
`define ADDR_VLDO_C 12'h014
`define ADDR_CTRL 12'h018

// Enable register fields.
`define EN_BUCK_BIT 0
`define EN_LDO_A_BIT 1
`define EN_LDO_B_BIT 2
`define EN_LDO_C_BIT 3
`define EN_SEQDIS_BIT 4
`define EN_RESTART_BIT 5

// Status register fields.
`define ST_PGOOD_LSB 0
`define ST_UV_BIT 4
`define ST_TS_BIT 5

// Control register fields.
`define CTRL_INTEN_BIT 0

// Reset values.
`define RST_ENABLE 8'h20
`define RST_CTRL 8'h00
`define RST_VOLT 8'h00

// Power-good thresholds in percent of target.
`define PG_RISE_PCT 8'd90
`define PG_FALL_PCT 8'd85

// Detector filter length in cycles.
`define FILT_CYCLES 4'd3

`endif

/* rtl/pwr_seq_pkg.sv */
package pwr_seq_pkg;

  // Supply enable nibble: {ldo_c, ldo_b, ldo_a, buck}.
  typedef logic [3:0] supply_vec_type;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_RUN = 4'b0100,
    ST_FAULT = 4'b1000
  } seq_state_type;

  // Filtered pin and detector events.
  typedef struct packed {
    logic en_rise;
    logic en_fall;
    logic en_level;
    logic uv;
    logic ts;
  } pin_evt_type;

  // Output rail levels reported by analog monitors, in percent of target.
  typedef struct packed {
    logic [7:0] pct_c;
    logic [7:0] pct_b;
    logic [7:0] pct_a;
    logic [7:0] pct_buck;
  } rail_pct_type;

endpackage

/* rtl/pin_filter.sv */
`timescale 1ns/10ps
`include "pwr_seq_defs.svh"

// Two-flop synchroniser plus stability filter for one pin, with edge pulses.
module pin_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic [3:0] cnt_r;
  logic level_r;
  logic changed;

  assign changed = (s2_r != level_r) && (cnt_r == `FILT_CYCLES);

  // The first stage feeds only the second; a level must hold before it counts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      cnt_r <= 4'h0;
      level_r <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else if (ce) begin
      s1_r <= pin;
      s2_r <= s1_r;
      cnt_r <= (s2_r == level_r) ? 4'h0 : (changed ? 4'h0 : cnt_r + 4'h1);
      if (changed) level_r <= s2_r; // R26
      rise <= changed && s2_r;
      fall <= changed && !s2_r;
    end
  end

  assign level = level_r;
endmodule

/* rtl/pgood_mon.sv */
`timescale 1ns/10ps
`include "pwr_seq_defs.svh"

// Power-good flag with hysteresis for one rail.
module pgood_mon (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic on,
  input wire logic [7:0] pct,
  output logic good
);
  // Sets at the rising threshold, clears at the falling one or when off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      good <= 1'b0;
    end else if (ce) begin
      if (!on || pct <= `PG_FALL_PCT) good <= 1'b0; // R19
      else if (pct >= `PG_RISE_PCT) good <= 1'b1; // R19
    end
  end
endmodule

/* bench/rail_model.sv */
`timescale 1ns/10ps

// Stands in for the four regulator outputs seen by the power-good monitors.
module rail_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] on,
  output pwr_seq_pkg::rail_pct_type rail_pct
);
  logic [7:0] pct_r [4];

  // Each rail climbs ten percent a cycle while driven and sinks ten percent a cycle once released.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) pct_r[i] <= 8'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (on[i] && pct_r[i] < 8'd100) pct_r[i] <= pct_r[i] + 8'd10;
        else if (!on[i] && pct_r[i] != 8'h00) pct_r[i] <= pct_r[i] - 8'd10;
      end
    end
  end

  // The packed struct runs from rail c down to the buck rail.
  assign rail_pct = {pct_r[3], pct_r[2], pct_r[1], pct_r[0]};
endmodule

/* bench/pmic_power_sequence_fault_ctrl_tb_top.sv */
`timescale 1ns/10ps
`include "pwr_seq_defs.svh"

module pmic_power_sequence_fault_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, enable_pin, uv, ts;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, volt_settings;
  logic pready, pslverr, err, bias_on, fault_irq_n, buck_on, a_on, b_on, c_on;
  pwr_seq_pkg::rail_pct_type rail_pct;
  int error_cnt, tests_run;
  wire logic [3:0] sup = {c_on, b_on, a_on, buck_on};
  wire logic [3:0] ns_sup;

  pwr_seq_ctrl uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enable_pin(enable_pin), .undervoltage_lockout(uv), .thermal_shutdown(ts),
    .rail_pct(rail_pct), .buck_reg_on(buck_on), .linear_reg_a_on(a_on), .linear_reg_b_on(b_on),
    .linear_reg_c_on(c_on), .bias_on(bias_on), .volt_settings(volt_settings),
    .fault_irq_n(fault_irq_n));

  rail_model partner (.pclk(pclk), .presetn(presetn), .on(sup), .rail_pct(rail_pct));

  // A no-sequence variant that follows the same pins; its bus stays idle.
  pwr_seq_ctrl #(.SEQ_ENABLED(1'b0)) noseq (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(1'b0),
    .penable(1'b0), .pwrite(1'b0), .paddr(12'h000), .pwdata(32'h0), .prdata(), .pready(), .pslverr(),
    .enable_pin(enable_pin), .undervoltage_lockout(uv), .thermal_shutdown(ts), .rail_pct(rail_pct),
    .buck_reg_on(ns_sup[0]), .linear_reg_a_on(ns_sup[1]), .linear_reg_b_on(ns_sup[2]),
    .linear_reg_c_on(ns_sup[3]), .bias_on(), .volt_settings(), .fault_irq_n());

  // Free-running 125 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Prints the tallies and the verdict, then stops the run.
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compares one observed value with its expectation.
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      check("pready wait", {31'h0, pready}, 32'h1);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares the whole word.
  task rdc(input string what, input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(what, rd, exp);
  endtask

  // Waits for the supply outputs to settle; while coming up, the a, buck, b, c order is watched.
  task wait_sup(input logic [3:0] exp);
    int n;
    n = 0;
    while (sup !== exp && n < 300) begin
      @(posedge pclk);
      #1;
      if (exp == 4'hf && ((sup[0] && !sup[1]) || (sup[2] && !sup[0]) || (sup[3] && !sup[2])))
        check("power-up order", {28'h0, sup}, 32'hf);
      n++;
    end
    if (sup !== exp) begin
      check("supply wait", {28'h0, sup}, {28'h0, exp});
      finish_test();
    end
  endtask

  task pin(input logic v);
    @(posedge pclk);
    enable_pin <= v;
  endtask

  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Main sequence: pin startup and shutdown, bus shutdown, faults, hot start after reset.
  initial begin
    {presetn, psel, penable, pwrite, enable_pin, uv, ts} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    idle(10);
    presetn <= 1'b1;
    rdc("enable at reset", `ADDR_ENABLE, 32'h20);
    rdc("ctrl at reset", `ADDR_CTRL, 32'h0);
    rdc("buck voltage at reset", `ADDR_VBUCK, 32'h10);
    check("supplies quiet", {28'h0, sup}, 32'h0);
    check("irq idle", {31'h0, fault_irq_n}, 32'h1);
    rdc("unmapped read", 12'h01c, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    pin(1'b1);
    wait_sup(4'hf);
    check("no-seq single supply", {28'h0, ns_sup}, 32'h1);
    rdc("enable after startup", `ADDR_ENABLE, 32'h2f);
    idle(12);
    rdc("power good all", `ADDR_STATUS, 32'h0f);
    apb(1'b1, `ADDR_VBUCK, 32'h33);
    #1;
    check("buck voltage applied", {24'h0, volt_settings[7:0]}, 32'h33);
    apb(1'b1, `ADDR_VLDO_C, 32'h2a);
    #1;
    check("ldo c voltage applied", {24'h0, volt_settings[31:24]}, 32'h2a);
    rdc("ldo c voltage read", `ADDR_VLDO_C, 32'h2a);
    pin(1'b0);
    wait_sup(4'h0);
    check("no-seq off", {28'h0, ns_sup}, 32'h0);
    idle(2);
    check("bias off after pin fall", {31'h0, bias_on}, 32'h0);
    rdc("enable after pin fall", `ADDR_ENABLE, 32'h20);
    rdc("power good cleared", `ADDR_STATUS, 32'h0);
    // The pin is left alone while the bus shuts the part down.
    pin(1'b1);
    wait_sup(4'hf);
    check("voltages reloaded at startup", volt_settings, 32'h1414_1410);
    apb(1'b1, `ADDR_ENABLE, 32'h20);
    wait_sup(4'h0);
    idle(20);
    check("steady high level", {28'h0, sup}, 32'h0);
    pin(1'b0);
    idle(20);
    check("late pin fall", {28'h0, sup}, 32'h0);
    check("bias stays off", {31'h0, bias_on}, 32'h0);
    rdc("enable untouched", `ADDR_ENABLE, 32'h20);
    // Thermal fault with restart enabled.
    apb(1'b1, `ADDR_CTRL, 32'h1);
    pin(1'b1);
    wait_sup(4'hf);
    apb(1'b1, `ADDR_VBUCK, 32'h33);
    @(posedge pclk);
    ts <= 1'b1;
    wait_sup(4'h0);
    check("bias kept in thermal fault", {31'h0, bias_on}, 32'h1);
    rdc("thermal flag", `ADDR_STATUS, 32'h20);
    check("irq on thermal", {31'h0, fault_irq_n}, 32'h0);
    rdc("voltage reloaded", `ADDR_VBUCK, 32'h10);
    check("voltage word reloaded", volt_settings, 32'h1414_1410);
    @(posedge pclk);
    ts <= 1'b0;
    wait_sup(4'hf);
    idle(12);
    rdc("flag persists", `ADDR_STATUS, 32'h2f);
    apb(1'b1, `ADDR_STATUS, 32'h20);
    idle(2);
    check("irq released", {31'h0, fault_irq_n}, 32'h1);
    rdc("flag cleared", `ADDR_STATUS, 32'h0f);
    // Undervoltage with restart off; sequencing is disabled by the same enable write that sets the supply bits.
    apb(1'b1, `ADDR_ENABLE, 32'h1f);
    @(posedge pclk);
    uv <= 1'b1;
    wait_sup(4'h0);
    rdc("enable after fault", `ADDR_ENABLE, 32'h0);
    check("irq on undervoltage", {31'h0, fault_irq_n}, 32'h0);
    apb(1'b1, `ADDR_STATUS, 32'h10);
    idle(2);
    rdc("persisting fault", `ADDR_STATUS, 32'h10);
    check("irq reasserted", {31'h0, fault_irq_n}, 32'h0);
    @(posedge pclk);
    uv <= 1'b0;
    idle(60);
    check("no restart", {28'h0, sup}, 32'h0);
    // Supply loss reset with the pin held high.
    @(posedge pclk);
    presetn <= 1'b0;
    idle(10);
    presetn <= 1'b1;
    wait_sup(4'hf);
    check("no-seq hot start", {28'h0, ns_sup}, 32'h1);
    idle(12);
    rdc("flags cleared by reset", `ADDR_STATUS, 32'h0f);
    finish_test();
  end
endmodule
